// ==== hw/fpm_mapper.sv ====
// process data mapper with link receiver and byte fifo
`timescale 1ns/1ps

// small synchronous fifo, flip-flop storage
module fpm_fifo import fpm_pkg::*; #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wp;
    logic [AW:0]                 rp;
  } fpm_fifo_state_type;

  fpm_fifo_state_type q;
  fpm_fifo_state_type d;

  // extra pointer bit tells full from empty
  assign in_ready  = !((q.wp[AW-1:0] == q.rp[AW-1:0]) && (q.wp[AW] != q.rp[AW]));
  assign out_valid = (q.wp != q.rp);
  assign out_data  = q.mem[q.rp[AW-1:0]];

  // pointer and storage update
  always_comb begin
    d = q;
    if (in_valid && in_ready) begin
      d.mem[q.wp[AW-1:0]] = in_data;
      d.wp = q.wp + 1'b1;
    end
    if (out_valid && out_ready) begin
      d.rp = q.rp + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

// top: link receiver, frame assembly, control byte decode, diagnosis
module fpm_mapper import fpm_pkg::*; #(
  parameter int unsigned HOLD_CYCLES = OUT_HOLD_CYCLES
) (
  input  wire logic           ref_clk,
  input  wire logic           reset,
  input  wire logic           serial_rx,
  input  wire logic           err_out_pin,
  input  wire logic           stat_out_pin,
  input  wire logic           prm_valid,
  input  wire logic [4:0]     prm_in_bytes,
  input  wire logic           cfg_valid,
  input  wire logic [15:0]    cfg_id,
  input  wire logic           out_valid,
  input  wire logic [7:0]     out_byte,
  input  wire logic           trig_select,
  input  wire logic [7:0]     sensor_err_code,
  input  wire logic           if_fault,
  input  wire logic [7:0]     if_err_code,
  input  wire logic [7:0]     sys_err_code,
  output fpm_layout_type      layout,
  output logic                data_exchange,
  output fpm_frame_type       frame,
  output logic                frame_valid,
  output fpm_ctrl_type        ctrl,
  output fpm_diag_type        diag,
  output logic                update_busy,
  output logic                link_overrun
);
  localparam int unsigned CW = $clog2(BIT_CYCLES);
  localparam int unsigned GW = $clog2(GAP_CYCLES);
  localparam int unsigned HW = $clog2(HOLD_CYCLES + 1);

  typedef struct packed {
    logic [1:0]      rx_sync;
    logic [1:0]      err_sync;
    logic [1:0]      stat_sync;
    fpm_rx_type      rx_state;
    logic [CW-1:0]   rx_cnt;
    logic [2:0]      rx_bit;
    logic [7:0]      rx_shift;
    logic            push;
    logic            overrun;
    logic [GW-1:0]   gap;
    logic            locked;
    fpm_layout_type  layout;
    logic            exchange;
    fpm_frame_type   rec;
    logic [3:0]      idx;
    logic            pending;
    fpm_frame_type   frame;
    logic            frame_valid;
    logic [7:0]      out_prev;
    fpm_ctrl_type    ctrl;
    logic [HW-1:0]   hold;
    logic            busy;
    fpm_diag_type    diag;
  } fpm_state_type;

  fpm_state_type q;
  fpm_state_type d;
  logic          in_ready;
  logic          fifo_valid;
  logic [7:0]    fifo_data;
  logic          pop;

  // magnitude of a two's complement word
  function automatic logic [31:0] mag32(input logic [31:0] v);
    return v[31] ? (~v + 32'h0000_0001) : v;
  endfunction

  // record bytes wait here while a finished frame is held back
  fpm_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .in_valid  (q.push),
    .in_data   (q.rx_shift),
    .in_ready  (in_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (pop)
  );

  // stall draining while a complete record awaits publication
  assign pop = !q.pending;

  always_comb begin
    logic [31:0] vel;
    logic [31:0] len;
    logic        long_v;
    fpm_frame_type f;
    vel = '0;
    len = '0;
    long_v = 1'b0;
    f = q.rec;
    d = q;
    d.push = 1'b0;
    d.frame_valid = 1'b0;
    d.ctrl.clear_diag = 1'b0;
    d.ctrl.restore_req = 1'b0;

    // two-stage synchronisers for pins
    d.rx_sync   = {q.rx_sync[0], serial_rx};
    d.err_sync  = {q.err_sync[0], err_out_pin};
    d.stat_sync = {q.stat_sync[0], stat_out_pin};

    // 8n1 receiver, centre sampled, no parity bit
    case (q.rx_state)
      RX_IDLE: begin
        if (!q.rx_sync[1]) begin
          d.rx_state = RX_START;
          d.rx_cnt = CW'(HALF_CYCLES - 1);
        end
      end
      RX_START: begin
        if (q.rx_cnt == '0) begin
          // a glitch shorter than half a bit is dropped
          d.rx_state = q.rx_sync[1] ? RX_IDLE : RX_DATA;
          d.rx_cnt = CW'(BIT_CYCLES - 1);
          d.rx_bit = 3'h0;
        end else begin
          d.rx_cnt = q.rx_cnt - 1'b1;
        end
      end
      RX_DATA: begin
        if (q.rx_cnt == '0) begin
          d.rx_shift = {q.rx_sync[1], q.rx_shift[7:1]};
          d.rx_cnt = CW'(BIT_CYCLES - 1);
          d.rx_bit = q.rx_bit + 1'b1;
          if (q.rx_bit == 3'h7) begin
            d.rx_state = RX_STOP;
          end
        end else begin
          d.rx_cnt = q.rx_cnt - 1'b1;
        end
      end
      RX_STOP: begin
        if (q.rx_cnt == '0) begin
          d.rx_state = RX_IDLE;
          d.push = q.rx_sync[1]; // framing errors are discarded
        end else begin
          d.rx_cnt = q.rx_cnt - 1'b1;
        end
      end
      default: begin
        d.rx_state = RX_IDLE;
      end
    endcase

    // sticky flag: a byte was lost because the fifo was full
    if (q.push && !in_ready) begin
      d.overrun = 1'b1;
    end

    // first parameter setting picks the layout for good
    if (prm_valid && !q.locked) begin
      d.locked = 1'b1;
      d.layout = fpm_layout_of(prm_in_bytes);
    end

    // exchange only with a matching configuration
    if (cfg_valid) begin
      d.exchange = (q.layout != layout_none) &&
                   (cfg_id == {fpm_id_of(q.layout), CFG_ID_TAIL});
    end

    // idle line gap realigns the record to its first byte
    if (q.rx_state != RX_IDLE || fifo_valid) begin
      d.gap = '0;
    end else if (q.gap != GW'(GAP_CYCLES - 1)) begin
      d.gap = q.gap + 1'b1;
    end else if (!q.pending) begin
      d.idx = 4'h0;
    end

    // collect record bytes; without a layout they are drained and dropped
    if (pop && fifo_valid && q.layout != layout_none) begin
      d.rec[q.idx] = fifo_data;
      if ({1'b0, q.idx} == fpm_len_of(q.layout) - 5'h01) begin
        d.idx = 4'h0;
        d.pending = 1'b1;
      end else begin
        d.idx = q.idx + 1'b1;
      end
    end

    // build published frame: magnitudes and status byte
    vel = f[POS_VEL +: 4];
    len = f[POS_LEN +: 4];
    f[POS_VEL +: 4] = mag32(vel);
    if (q.layout == layout_four || q.layout == layout_five || q.layout == frame_layout_six) begin
      f[POS_LEN +: 4] = mag32(len);
    end
    if (q.layout == frame_layout_six) begin
      f[POS_STATUS] = {4'h0, len[31], vel[31], q.stat_sync[1], q.err_sync[1]};
    end

    // whole frame replaced in one cycle so it is always consistent
    if (q.pending && q.hold == '0) begin
      d.frame = f;
      d.frame_valid = 1'b1;
      d.pending = 1'b0;
    end

    // hold-off after an output byte change
    if (q.hold != '0) begin
      d.hold = q.hold - 1'b1;
    end

    // control byte decode, only during data exchange
    if (out_valid && q.exchange) begin
      d.out_prev = out_byte;
      if (out_byte != q.out_prev) begin
        d.hold = HW'(HOLD_CYCLES);
      end
      d.ctrl.direction = out_byte[OB_DIR];
      d.ctrl.trig_first = out_byte[OB_TRIG1];
      d.ctrl.length_trigger_second = trig_select & out_byte[OB_STANDBY_B];
      d.ctrl.standby = trig_select ? out_byte[OB_STANDBY_A] : out_byte[OB_STANDBY_B];
      d.ctrl.clear_diag = out_byte[OB_CLEAR] & ~q.out_prev[OB_CLEAR];
      // edge detect: bit 7 must return low before a new restore (master side)
      if (out_byte[OB_RESTORE] && !q.out_prev[OB_RESTORE]) begin
        d.ctrl.restore_req = 1'b1;
        d.ctrl.restore_set = {out_byte[OB_SET_HI], out_byte[OB_SET_LO]};
      end
    end

    // busy flag registered so the port comes straight from a flop
    d.busy = (d.hold != '0);

    // diagnosis: clear first so a same-cycle error still lands
    if (q.ctrl.clear_diag) begin
      d.diag = '0;
    end
    if (sensor_err_code != 8'h00 || if_fault) begin
      long_v = if_fault || (d.diag.len == DIAG_LONG);
      d.diag.len = long_v ? DIAG_LONG : DIAG_SHORT;
      d.diag.bytes[0] = {5'h00, d.diag.len};
      if (sensor_err_code != 8'h00) begin
        d.diag.bytes[1] = sensor_err_code;
      end
      if (if_fault) begin
        d.diag.bytes[2] = if_err_code;
        d.diag.bytes[3] = sys_err_code;
      end
    end
  end

  // single state register, line idles high after reset
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      q <= '0;
      q.rx_sync <= 2'h3;
    end else begin
      q <= d;
    end
  end

  // every output comes from the state register
  assign layout        = q.layout;
  assign data_exchange = q.exchange;
  assign frame         = q.frame;
  assign frame_valid   = q.frame_valid;
  assign ctrl          = q.ctrl;
  assign diag          = q.diag;
  assign update_busy   = q.busy;
  assign link_overrun  = q.overrun;
endmodule

// ==== shared/fpm_pkg.sv ====
// constants, types and layout table of the fieldbus process data mapper
// Overview of operation
// - layout chosen from input byte count of first parameter setting after power-up
// - data exchange only when configured identifier matches a supported layout
// - layout one: 8 bytes counter, velocity, rate; identifier 0x97 0x20
// - layout two: 16 bytes, adds velocity integral and ms timer; 0xd7 0x20
// - layout three: 10 bytes, adds illumination and exposure; 0x99 0x20
// - layout four: 12 bytes, adds 32-bit length; 0x9b 0x20
// - layout five: 14 bytes, length, illumination, exposure; 0x9d 0x20
// - layout six: 15 bytes, length, error code, status, temperature; 0x9e 0x20
// - velocity and length sent as magnitudes without sign; rate passed on as received
// - status byte: error pin, status pin, speed sign, length sign, rest zero
// - diagnosis two bytes normally, four bytes when interface faults exist
// - output bit 0 enters standby when it is the selected source
// - output bit 1 gives direction of travel
// - bit 3 is first length trigger, bit 2 standby or second trigger
// - rising edge of output bit 4 clears error list and diagnosis
// - bit 7 set restores parameter set numbered by bits 6 and 5
// - standby follows bit 2, or bit 0 when trigger select is one
// - each output byte change delays input frame update by 3 ms
// - internal serial link runs at 57600 baud without parity
// - velocity unsigned; direction only in status byte
package fpm_pkg;
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned LINK_BAUD       = 57600;
  localparam int unsigned BIT_CYCLES      = (CLK_HZ + LINK_BAUD / 2) / LINK_BAUD;
  localparam int unsigned HALF_CYCLES     = BIT_CYCLES / 2;
  localparam int unsigned GAP_CYCLES      = 20 * BIT_CYCLES;
  localparam int unsigned OUT_HOLD_MS     = 3;
  localparam int unsigned OUT_HOLD_CYCLES = OUT_HOLD_MS * (CLK_HZ / 1000);
  localparam int unsigned MAX_IN_BYTES    = 15;
  localparam int unsigned FIFO_DEPTH      = 8;
  // configuration identifier bytes
  localparam logic [7:0] CFG_ID_TAIL = 8'h20;
  localparam logic [7:0] CFG_ID_L1   = 8'h97;
  localparam logic [7:0] CFG_ID_L2   = 8'hd7;
  localparam logic [7:0] CFG_ID_L3   = 8'h99;
  localparam logic [7:0] CFG_ID_L4   = 8'h9b;
  localparam logic [7:0] CFG_ID_L5   = 8'h9d;
  localparam logic [7:0] CFG_ID_L6   = 8'h9e;
  // input byte counts per layout
  localparam logic [4:0] IN_BYTES_L1 = 5'h08;
  localparam logic [4:0] IN_BYTES_L2 = 5'h10;
  localparam logic [4:0] IN_BYTES_L3 = 5'h0a;
  localparam logic [4:0] IN_BYTES_L4 = 5'h0c;
  localparam logic [4:0] IN_BYTES_L5 = 5'h0e;
  localparam logic [4:0] IN_BYTES_L6 = 5'h0f;
  // byte positions inside the input frame, byte 0 first
  localparam int unsigned POS_VEL    = 2;
  localparam int unsigned POS_LEN    = 8;
  localparam int unsigned POS_STATUS = 13;
  // output byte bit positions
  localparam int unsigned OB_STANDBY_A = 0;
  localparam int unsigned OB_DIR       = 1;
  localparam int unsigned OB_STANDBY_B = 2;
  localparam int unsigned OB_TRIG1     = 3;
  localparam int unsigned OB_CLEAR     = 4;
  localparam int unsigned OB_SET_LO    = 5;
  localparam int unsigned OB_SET_HI    = 6;
  localparam int unsigned OB_RESTORE   = 7;
  // diagnosis lengths
  localparam logic [2:0] DIAG_NONE  = 3'h0;
  localparam logic [2:0] DIAG_SHORT = 3'h2;
  localparam logic [2:0] DIAG_LONG  = 3'h4;

  typedef enum logic [2:0] {
    layout_none      = 3'h0,
    frame_layout_one = 3'h1,
    layout_two       = 3'h2,
    layout_three     = 3'h3,
    layout_four      = 3'h4,
    layout_five      = 3'h5,
    frame_layout_six = 3'h6
  } fpm_layout_type;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'h0,
    RX_START = 2'h1,
    RX_DATA  = 2'h2,
    RX_STOP  = 2'h3
  } fpm_rx_type;

  typedef logic [0:MAX_IN_BYTES-1][7:0] fpm_frame_type;

  typedef struct packed {
    logic       standby;
    logic       direction;
    logic       trig_first;
    logic       length_trigger_second;
    logic       clear_diag;
    logic       restore_req;
    logic [1:0] restore_set;
  } fpm_ctrl_type;

  typedef struct packed {
    logic [2:0]       len;
    logic [0:3][7:0]  bytes;
  } fpm_diag_type;

  // layout from configured input byte count
  function automatic fpm_layout_type fpm_layout_of(input logic [4:0] n);
    case (n)
      IN_BYTES_L1: return frame_layout_one;
      IN_BYTES_L2: return layout_two;
      IN_BYTES_L3: return layout_three;
      IN_BYTES_L4: return layout_four;
      IN_BYTES_L5: return layout_five;
      IN_BYTES_L6: return frame_layout_six;
      default:     return layout_none;
    endcase
  endfunction

  function automatic logic [4:0] fpm_len_of(input fpm_layout_type l);
    case (l)
      frame_layout_one: return IN_BYTES_L1;
      layout_two:       return IN_BYTES_L2;
      layout_three:     return IN_BYTES_L3;
      layout_four:      return IN_BYTES_L4;
      layout_five:      return IN_BYTES_L5;
      frame_layout_six: return IN_BYTES_L6;
      default:          return 5'h00;
    endcase
  endfunction

  function automatic logic [7:0] fpm_id_of(input fpm_layout_type l);
    case (l)
      frame_layout_one: return CFG_ID_L1;
      layout_two:       return CFG_ID_L2;
      layout_three:     return CFG_ID_L3;
      layout_four:      return CFG_ID_L4;
      layout_five:      return CFG_ID_L5;
      frame_layout_six: return CFG_ID_L6;
      default:          return 8'h00;
    endcase
  endfunction
endpackage

// ==== verification/fpm_link_src.sv ====
// sensor core link sender model for the mapper bench
`timescale 1ns/1ps
module fpm_link_src import fpm_pkg::*; (
  input  wire logic ref_clk,
  output logic      serial_rx
);
  // idle line stays high between bytes
  initial serial_rx = 1'b1;

  // start bit, eight data bits lsb first, no parity, one stop bit
  task automatic send(input logic [7:0] x);
    logic [9:0] f;
    f = {1'b1, x, 1'b0};
    for (int i = 0; i < 10; i++) begin
      serial_rx = f[i];
      repeat (BIT_CYCLES) @(negedge ref_clk);
    end
  endtask
endmodule

// ==== verification/fpm_mapper_monitor.sv ====
// port checker for the process data mapper
`timescale 1ns/1ps
module fpm_mapper_monitor import fpm_pkg::*; #(
  parameter int unsigned HOLD_CYCLES = OUT_HOLD_CYCLES
) (
  input wire logic           ref_clk,
  input wire logic           reset,
  input wire logic           prm_valid,
  input wire logic [4:0]     prm_in_bytes,
  input wire logic           cfg_valid,
  input wire logic [15:0]    cfg_id,
  input wire logic           out_valid,
  input wire logic [7:0]     out_byte,
  input wire logic           trig_select,
  input wire logic           if_fault,
  input wire fpm_layout_type layout,
  input wire logic           data_exchange,
  input wire fpm_frame_type  frame,
  input wire logic           frame_valid,
  input wire fpm_ctrl_type   ctrl,
  input wire fpm_diag_type   diag,
  input wire logic           update_busy
);
  logic       take;
  logic       seen_q;
  logic [7:0] prev_q;
  // a byte counts only while data exchange runs
  assign take = out_valid & data_exchange;
  // shadow of the last taken byte, needed for edge checks
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      prev_q <= 8'h00;
      seen_q <= 1'b0;
    end else begin
      if (take) prev_q <= out_byte;
      if (prm_valid) seen_q <= 1'b1;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  AST_LAYOUT_SIX: assert property (
    prm_valid && !seen_q && prm_in_bytes == IN_BYTES_L6 |=> layout == frame_layout_six)
    else $error("layout not picked");
  AST_LAYOUT_HOLD: assert property (layout != layout_none |=> $stable(layout))
    else $error("layout moved");
  AST_NO_EXCHANGE: assert property (layout == layout_none |-> !data_exchange)
    else $error("exchange without layout");
  AST_ID_SIX: assert property (cfg_valid && layout == frame_layout_six |=>
    data_exchange == ($past(cfg_id) == {CFG_ID_L6, CFG_ID_TAIL}))
    else $error("identifier match wrong");
  AST_CLEAR_RISE: assert property (
    take && out_byte[OB_CLEAR] && !prev_q[OB_CLEAR] |=> ctrl.clear_diag)
    else $error("clear missing");
  AST_CLEAR_ONLY: assert property (ctrl.clear_diag |-> $past(take) && prev_q[OB_CLEAR])
    else $error("clear without cause");
  AST_RESTORE: assert property (take && out_byte[OB_RESTORE] && !prev_q[OB_RESTORE] |=>
    ctrl.restore_req && ctrl.restore_set == prev_q[OB_SET_HI:OB_SET_LO])
    else $error("restore wrong");
  AST_STANDBY: assert property (take |=>
    ctrl.standby == (trig_select ? prev_q[OB_STANDBY_A] : prev_q[OB_STANDBY_B]))
    else $error("standby source wrong");
  AST_DIR_TRIG: assert property (take |=> ctrl.direction == prev_q[OB_DIR] &&
    ctrl.trig_first == prev_q[OB_TRIG1] && ctrl.length_trigger_second == (trig_select & prev_q[OB_STANDBY_B]))
    else $error("direction or trigger wrong");
  AST_HOLD: assert property (
    take && out_byte != prev_q && HOLD_CYCLES >= 8 |=> update_busy [*8])
    else $error("hold too short");
  AST_FRAME_PULSE: assert property (frame_valid |=> !frame_valid)
    else $error("frame strobe too long");
  AST_STATUS: assert property (
    frame_valid && layout == frame_layout_six |-> frame[POS_STATUS][7:4] == 4'h0)
    else $error("status reserved bits set");
  AST_LONG_DIAG: assert property (if_fault [*4] |-> diag.len == DIAG_LONG)
    else $error("long diagnosis missing");
  cover property (frame_valid);
  cover property (ctrl.restore_req);
  cover property (diag.len == DIAG_LONG);
endmodule

bind fpm_mapper fpm_mapper_monitor #(.HOLD_CYCLES(HOLD_CYCLES)) u_mon (.ref_clk, .reset, .prm_valid,
  .prm_in_bytes, .cfg_valid, .cfg_id, .out_valid, .out_byte, .trig_select, .if_fault, .layout,
  .data_exchange, .frame, .frame_valid, .ctrl, .diag, .update_busy);

// ==== verification/fpm_mapper_test.sv ====
// self-checking bench for the process data mapper
`timescale 1ns/1ps
module fpm_mapper_test import fpm_pkg::*;;
  localparam int unsigned HOLD = 20; // short hold keeps the run brief
  logic           ref_clk = 1'b0;
  logic           reset = 1'b1;
  logic           serial_rx, err_out_pin, stat_out_pin, prm_valid, cfg_valid, out_valid;
  logic           trig_select, if_fault, data_exchange, frame_valid, update_busy, link_overrun;
  logic [4:0]     prm_in_bytes;
  logic [15:0]    cfg_id;
  logic [7:0]     out_byte, sensor_err_code, if_err_code, sys_err_code, pv, b, exp8;
  logic [1:0]     pset;
  logic [31:0]    v;
  logic [119:0]   rec, exp_frame;
  fpm_layout_type layout;
  fpm_frame_type  frame, got_frame;
  fpm_ctrl_type   ctrl;
  fpm_diag_type   diag;
  int             mismatches, tests_run, n_frames;
  int unsigned    rs = 8279;
  logic [4:0]     cnt[7] = '{5'h09, 5'h08, 5'h10, 5'h0a, 5'h0c, 5'h0e, 5'h0f};
  logic [7:0]     ids[7] = '{8'h97, 8'h97, 8'hd7, 8'h99, 8'h9b, 8'h9d, 8'h9e};

  always #50 ref_clk = ~ref_clk;

  fpm_mapper #(.HOLD_CYCLES(HOLD)) u_dut (.ref_clk, .reset, .serial_rx, .err_out_pin, .stat_out_pin,
    .prm_valid, .prm_in_bytes, .cfg_valid, .cfg_id, .out_valid, .out_byte, .trig_select,
    .sensor_err_code, .if_fault, .if_err_code, .sys_err_code, .layout, .data_exchange,
    .frame, .frame_valid, .ctrl, .diag, .update_busy, .link_overrun);
  fpm_link_src u_src (.ref_clk, .serial_rx);

  function automatic logic [7:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs[7:0];
  endfunction

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic do_reset();
    reset = 1'b1;
    cyc(12);
    reset = 1'b0;
  endtask

  // strobes last one cycle; calls may follow back to back with no idle edge between
  task automatic prm(input logic [4:0] n);
    prm_valid = 1'b1;
    prm_in_bytes = n;
    cyc(1);
    prm_valid = 1'b0;
  endtask

  task automatic cfg(input logic [15:0] id);
    cfg_valid = 1'b1;
    cfg_id = id;
    cyc(1);
    cfg_valid = 1'b0;
  endtask

  task automatic put(input logic [7:0] x);
    out_valid = 1'b1;
    out_byte = x;
    cyc(1);
    out_valid = 1'b0;
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // catch every frame strobe, so a doubled or missing one shows
  always @(negedge ref_clk) begin
    if (frame_valid === 1'b1) begin
      n_frames++;
      got_frame = frame;
    end
  end

  // two records take about 55000 cycles, so 90000 means a hang
  initial begin
    #(90000 * 100);
    mismatches++;
    tally_and_finish();
  end

  initial begin
    {prm_valid, cfg_valid, out_valid, trig_select, if_fault, err_out_pin, stat_out_pin} = '0;
    {prm_in_bytes, cfg_id, out_byte, sensor_err_code, if_err_code, sys_err_code} = '0;
    // every layout, plus an unsupported count at index 0
    for (int i = 0; i < 7; i++) begin
      do_reset();
      chk({layout, data_exchange, ctrl}, 12'h000);
      prm(cnt[i]);
      chk(layout, i);
      cfg({ids[i], 8'h21});
      chk(data_exchange, 1'b0);
      put(8'h9f);
      chk(ctrl, 8'h00);
      cfg({ids[i], 8'h20});
      chk(data_exchange, i != 0);
      prm(5'h08);
      chk(layout, i);
    end
    $display("done: layouts");
    // random output bytes against the control model
    pv = 8'h00;
    pset = 2'h0;
    for (int k = 0; k < 40; k++) begin
      b = rnd();
      trig_select = b[0];
      cyc(1);
      b = rnd();
      if (pv[7]) b[7] = 1'b0;
      put(b);
      exp8 = {trig_select ? b[0] : b[2], b[1], b[3], trig_select & b[2], b[4] & ~pv[4], b[7] & ~pv[7],
              (b[7] & ~pv[7]) ? b[6:5] : pset};
      chk(ctrl, exp8);
      chk(update_busy, b != pv);
      if (b[7] & ~pv[7]) pset = b[6:5];
      pv = b;
      cyc(HOLD + 5);
      chk(update_busy, 1'b0);
    end
    $display("done: control byte");
    // diagnosis grows with an interface fault and clears on bit 4 rising
    sensor_err_code = 8'h35;
    cyc(4);
    chk({diag.len, diag.bytes[0:1]}, {3'h2, 16'h0235});
    {if_fault, if_err_code, sys_err_code} = {1'b1, 16'ha1b2};
    cyc(4);
    chk(diag, {3'h4, 32'h0435a1b2});
    {if_fault, sensor_err_code} = '0;
    cyc(4);
    chk(diag.len, 3'h4);
    put(8'h00);
    cyc(1);
    put(8'h10);
    cyc(3);
    chk(diag, 35'h0);
    $display("done: diagnosis");
    // one random record in layout six with a negative velocity
    err_out_pin = 1'b1;
    cyc(HOLD + 5);
    for (int j = 0; j < 15; j++) rec[119-8*j -: 8] = rnd();
    rec[103] = 1'b1;
    exp_frame = rec;
    v = rec[103:72];
    exp_frame[103:72] = v[31] ? -v : v;
    v = rec[55:24];
    exp_frame[55:24] = v[31] ? -v : v;
    exp_frame[15:8] = {4'h0, rec[55], rec[103], 2'b01};
    n_frames = 0;
    for (int j = 0; j < 15; j++) u_src.send(rec[119-8*j -: 8]);
    cyc(50);
    chk(n_frames, 1);
    chk(got_frame, exp_frame);
    chk(link_overrun, 1'b0);
    $display("done: frame");
    // second record through the byte buffer, positive velocity, negative length, status pin up
    {err_out_pin, stat_out_pin} = 2'b01;
    cyc(4);
    for (int j = 0; j < 15; j++) rec[119-8*j -: 8] = rnd();
    rec[103] = 1'b0;
    rec[55] = 1'b1;
    exp_frame = rec;
    v = rec[55:24];
    exp_frame[55:24] = -v;
    exp_frame[15:8] = {4'h0, 1'b1, 1'b0, 2'b10};
    n_frames = 0;
    for (int j = 0; j < 15; j++) u_src.send(rec[119-8*j -: 8]);
    cyc(50);
    chk(n_frames, 1);
    chk(got_frame, exp_frame);
    chk(link_overrun, 1'b0);
    $display("done: second frame");
    tally_and_finish();
  end
endmodule
